//--- eds_decode.sv
// pure decode of one data-space address under the two control bits
// assumes a 16-bit data address and synchronous use by eds_top
`timescale 1ns/1ps
`include "eds_map.svh"
module eds_decode (
   input wire logic [15:0] i_addr,
   input wire logic i_we,
   input wire logic i_lowpg,
   output logic o_io,
   output logic o_low_ram,
   output logic o_high_ram,
   output logic o_rom,
   output logic o_int,
   output logic [15:0] o_bus_addr
);
   // ==============================
   // region decode
   always_comb begin
      o_io = 1'b0;
      o_low_ram = 1'b0;
      o_high_ram = 1'b0;
      o_rom = 1'b0;
      o_int = (i_addr <= `EDS_INT_RAM_TOP);
      o_bus_addr = i_addr;
      if (i_addr >= `EDS_EXT_BASE) begin
         if (i_we) begin
            o_rom = 1'b1;
            // top bit grounded so 0x8000 lands on program word zero
            if (i_lowpg) begin
               o_bus_addr[`EDS_ADDR_TOP_BIT] = 1'b0;
            end
         end else if (i_addr <= `EDS_IO_TOP) begin
            o_io = 1'b1;
         end else if (i_addr <= `EDS_LOW_RAM_TOP) begin
            o_low_ram = 1'b1;
         end else begin
            o_high_ram = 1'b1;
         end
      end
   end
endmodule : eds_decode

//--- eds_map.svh
// constants for the external data-space decoder: address bounds, control bit positions
// assumes inclusion by eds_pkg users; definitions only
// Function
// - both control bits clear: io strobe for 16384 to 16639
// - both clear: low ram strobe 16640-32767, high ram strobe 32768-65535
// - write enable set: program rom strobe replaces io/ram strobes from 16384 up
// - with low-page bit clear, only program locations 16384-65535 reachable; 0-16383 stay unreachable
// - low-page bit with write enable forces address bit 15 low
// - config 0x4800 and data write at 32768 writes program location zero
// - no interrupt or fault flag for dual external access; no vector 0x1c
// - cache loop fetches externally only on first pass; dual access once
// - dual external access sequenced: program side first, then data side
`ifndef EDS_MAP_SVH
`define EDS_MAP_SVH
// ==============================
// address bounds
`define EDS_INT_RAM_TOP 16'h0fff
`define EDS_EXT_BASE 16'h4000
`define EDS_IO_TOP 16'h40ff
`define EDS_LOW_RAM_TOP 16'h7fff
// ==============================
// configuration word fields
`define EDS_CFG_WE_BIT 11
`define EDS_CFG_LOWPG_BIT 14
`define EDS_CFG_RESET 16'h0000
`define EDS_ADDR_TOP_BIT 15
`endif

//--- eds_mem_model.sv
// external memory side: counts program memory reads seen on the strobes, not writes
// assumes registered one-cycle strobes from eds_top
`timescale 1ns/1ps
module eds_mem_model (
   input wire logic i_clk,
   input wire logic i_prog_rom,
   input wire logic i_rd_wr_n,
   output int o_fetch_cnt
);
   // =====================
   // count reads of program memory, made by fetches and by data reads with write enable set
   int cnt = 0;
   always @(posedge i_clk) begin
      if (i_prog_rom && i_rd_wr_n) cnt <= cnt + 1;
   end
   assign o_fetch_cnt = cnt;
endmodule : eds_mem_model

//--- eds_monitor.sv
// checker for eds_top port behaviour
// assumes a bind from tb_top and one clock domain
`timescale 1ns/1ps
module eds_monitor (
   input wire logic i_clk,
   input wire logic i_rst_n,
   input wire logic i_cfg_wr,
   input wire logic [15:0] i_cfg_data,
   input wire logic o_done,
   input wire logic [15:0] o_addr,
   input wire logic o_rd_wr_n,
   input wire logic o_io,
   input wire logic o_low_ram,
   input wire logic o_high_ram,
   input wire logic o_prog_rom,
   input wire logic o_prog_write_enable,
   input wire logic o_low_page_prog_write
);
   // =====================
   // short aliases and steps
   default clocking @(posedge i_clk); endclocking
   default disable iff (!i_rst_n);
   wire we = o_prog_write_enable;
   wire lp = o_low_page_prog_write;
   wire data_stb = o_io | o_low_ram | o_high_ram;
   sequence s_x_read; o_prog_rom && o_rd_wr_n; endsequence
   sequence s_y_any; data_stb || o_prog_rom; endsequence
   // =====================
   // decode and sequencing
   chk_io_range: assert property (o_io |-> !we && o_addr inside {[16'h4000:16'h40ff]})
      else $error("io strobe out of range");
   chk_low_ram: assert property (o_low_ram |-> !we && o_addr inside {[16'h4100:16'h7fff]})
      else $error("low ram strobe out of range");
   chk_high_ram: assert property (o_high_ram |-> !we && o_addr[15])
      else $error("high ram strobe out of range");
   chk_rom_replace: assert property (we |-> !data_stb)
      else $error("data strobe while program write enabled");
   chk_rom_floor: assert property (o_prog_rom && !o_rd_wr_n && !lp |-> o_addr >= 16'h4000)
      else $error("program write below floor");
   chk_page_fold: assert property (o_prog_rom && !o_rd_wr_n && lp |-> !o_addr[15])
      else $error("address bit 15 not forced low");
   chk_cfg_bits: assert property (i_cfg_wr |=> we == $past(i_cfg_data[11]) && lp == $past(i_cfg_data[14]))
      else $error("config bits not taken");
   chk_x_first: assert property (s_x_read ##1 s_y_any |=> o_done)
      else $error("dual access not closed");
   property p_one_strobe;
      $onehot0({o_io, o_low_ram, o_high_ram, o_prog_rom}) and (data_stb |=> o_done);
   endproperty
   chk_one_strobe: assert property (p_one_strobe)
      else $error("strobes overlap or data strobe not last");
endmodule : eds_monitor

//--- eds_pkg.sv
// types for the external data-space decoder
// assumes eds_map.svh constants alongside
package eds_pkg;
   // ==============================
   // decoded target of a data access
   typedef enum logic [4:0] {
      EDS_TGT_NONE = 5'h01,
      EDS_TGT_INT = 5'h02,
      EDS_TGT_IO = 5'h04,
      EDS_TGT_RAM = 5'h08,
      EDS_TGT_ROM = 5'h10
   } eds_tgt_t;
   // sequencer states, one-hot
   typedef enum logic [2:0] {
      EDS_ST_IDLE = 3'h1,
      EDS_ST_X = 3'h2,
      EDS_ST_Y = 3'h4
   } eds_state_t;
endpackage : eds_pkg

//--- eds_top.sv
// external memory interface: data-space decode plus x/y access sequencer
// one instruction's program fetch and data access share the single bus
// assumes core presents one request per instruction, held until o_done
// assumes all inputs synchronous to i_clk; config arrives as a plain port write
`timescale 1ns/1ps
`include "eds_map.svh"
module eds_top (
   // clock and reset
   input wire logic i_clk,
   input wire logic i_rst_n,
   // configuration word
   input wire logic i_cfg_wr,
   input wire logic [15:0] i_cfg_data,
   // request from the core, one per instruction
   input wire logic i_req,
   input wire logic i_x_ext,
   input wire logic [15:0] i_x_addr,
   input wire logic i_y_ext,
   input wire logic [15:0] i_y_addr,
   input wire logic i_y_write,
   input wire logic i_from_cache,
   // handshake back to the core
   output logic o_done,
   // external bus side
   output logic [15:0] o_addr,
   output logic o_rd_wr_n,
   output logic o_io,
   output logic o_low_ram,
   output logic o_high_ram,
   output logic o_prog_rom,
   // configuration echo
   output logic o_prog_write_enable,
   output logic o_low_page_prog_write
);
   import eds_pkg::*;

   // ==============================
   // configuration state
   logic we_reg;
   logic we_next;
   logic lowpg_reg;
   logic lowpg_next;
   // sequencer state
   eds_state_t st_reg;
   eds_state_t st_next;
   logic done_reg;
   logic done_next;
   // bus drive state
   logic [15:0] addr_reg;
   logic [15:0] addr_next;
   logic rw_reg;
   logic rw_next;
   logic io_reg;
   logic io_next;
   logic lr_reg;
   logic lr_next;
   logic hr_reg;
   logic hr_next;
   logic rom_reg;
   logic rom_next;
   // decoded data-side target, combinational
   logic d_io;
   logic d_lr;
   logic d_hr;
   logic d_rom;
   logic d_int;
   logic [15:0] d_addr;

   // ==============================
   // reset image of the configuration word
   localparam logic [15:0] cfg_rst_word = `EDS_CFG_RESET;

   // ==============================
   // helpers
   // program fetch goes out unless the cache already holds the word
   function automatic logic x_on_bus(input logic x_ext, input logic cached);
      return x_ext && !cached;
   endfunction : x_on_bus

   // data step goes out only above internal ram; below it stays on chip
   function automatic logic y_on_bus(input logic y_ext, input logic is_int);
      return y_ext && !is_int;
   endfunction : y_on_bus

   // ==============================
   // data-side decode
   eds_decode u_dec (
      .i_addr(i_y_addr),
      .i_we(we_reg),
      .i_lowpg(lowpg_reg),
      .o_io(d_io),
      .o_low_ram(d_lr),
      .o_high_ram(d_hr),
      .o_rom(d_rom),
      .o_int(d_int),
      .o_bus_addr(d_addr)
   );

   // ==============================
   // configuration bits
   always_comb begin
      we_next = we_reg;
      lowpg_next = lowpg_reg;
      if (i_cfg_wr) begin
         we_next = i_cfg_data[`EDS_CFG_WE_BIT];
         lowpg_next = i_cfg_data[`EDS_CFG_LOWPG_BIT];
      end
   end
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         we_reg <= cfg_rst_word[`EDS_CFG_WE_BIT];
         lowpg_reg <= cfg_rst_word[`EDS_CFG_LOWPG_BIT];
      end else begin
         we_reg <= we_next;
         lowpg_reg <= lowpg_next;
      end
   end

   // ==============================
   // sequencer: program side first, data side second
   // no fault or interrupt output exists for the dual case by design
   always_comb begin
      st_next = st_reg;
      done_next = 1'b0;
      case (st_reg)
         // done_reg keeps a still-held request from being taken twice
         EDS_ST_IDLE: begin
            if (i_req && !done_reg) begin
               // cached instructions skip the external fetch after pass one
               if (x_on_bus(i_x_ext, i_from_cache)) begin
                  st_next = EDS_ST_X;
               end else if (y_on_bus(i_y_ext, d_int)) begin
                  st_next = EDS_ST_Y;
               end else begin
                  done_next = 1'b1;
               end
            end
         end
         // fetch is on the bus now; the data step waits its turn
         EDS_ST_X: begin
            if (y_on_bus(i_y_ext, d_int)) begin
               st_next = EDS_ST_Y;
            end else begin
               st_next = EDS_ST_IDLE;
               done_next = 1'b1;
            end
         end
         EDS_ST_Y: begin
            st_next = EDS_ST_IDLE;
            done_next = 1'b1;
         end
         default: begin
            st_next = EDS_ST_IDLE;
         end
      endcase
   end
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         st_reg <= EDS_ST_IDLE;
         done_reg <= 1'b0;
      end else begin
         st_reg <= st_next;
         done_reg <= done_next;
      end
   end

   // ==============================
   // bus drive: strobes follow the state being entered, one cycle each
   // keyed on st_next so strobe and state change on the same edge
   always_comb begin
      addr_next = addr_reg;
      rw_next = 1'b1;
      io_next = 1'b0;
      lr_next = 1'b0;
      hr_next = 1'b0;
      rom_next = 1'b0;
      case (st_next)
         // program-side fetch is always a read of program memory
         EDS_ST_X: begin
            addr_next = i_x_addr;
            rom_next = 1'b1;
         end
         // data step uses the decode under the current config bits
         EDS_ST_Y: begin
            addr_next = d_addr;
            rw_next = ~i_y_write;
            io_next = d_io;
            lr_next = d_lr;
            hr_next = d_hr;
            rom_next = d_rom;
         end
         default: begin
            addr_next = addr_reg;
         end
      endcase
   end
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         addr_reg <= 16'h0000;
         rw_reg <= 1'b1;
         io_reg <= 1'b0;
         lr_reg <= 1'b0;
         hr_reg <= 1'b0;
         rom_reg <= 1'b0;
      end else begin
         addr_reg <= addr_next;
         rw_reg <= rw_next;
         io_reg <= io_next;
         lr_reg <= lr_next;
         hr_reg <= hr_next;
         rom_reg <= rom_next;
      end
   end

   // ==============================
   // registered outputs, no logic between flop and pin
   // handshake
   assign o_done = done_reg;
   // bus side
   assign o_addr = addr_reg;
   assign o_rd_wr_n = rw_reg;
   assign o_io = io_reg;
   assign o_low_ram = lr_reg;
   assign o_high_ram = hr_reg;
   assign o_prog_rom = rom_reg;
   // configuration echo
   assign o_prog_write_enable = we_reg;
   assign o_low_page_prog_write = lowpg_reg;
endmodule : eds_top

//--- tb_top.sv
// self-checking bench for eds_top with an external memory model
// assumes 25 MHz clock and synchronous active-low reset
`timescale 1ns/1ps
module tb_top;
   import eds_pkg::*;
   logic i_clk = 0, i_rst_n = 0, i_cfg_wr = 0, i_req = 0, i_x_ext = 0, i_y_ext = 0;
   logic i_y_write = 1, i_from_cache = 0;
   logic [15:0] i_cfg_data = 0, i_x_addr = 0, i_y_addr = 0, o_addr;
   logic o_done, o_rd_wr_n, o_io, o_low_ram, o_high_ram, o_prog_rom, o_we, o_lp;
   logic [20:0] q[$];
   logic [51:0] rows[11] = '{{16'h0, 16'h4000, 4'h8, 16'h4000}, {16'h0, 16'h40ff, 4'h8, 16'h40ff},
      {16'h0, 16'h4100, 4'h4, 16'h4100}, {16'h0, 16'h7fff, 4'h4, 16'h7fff},
      {16'h0, 16'h8000, 4'h2, 16'h8000}, {16'h0, 16'hffff, 4'h2, 16'hffff},
      {16'h0800, 16'h4000, 4'h1, 16'h4000}, {16'h0800, 16'hffff, 4'h1, 16'hffff},
      {16'h4800, 16'h8000, 4'h1, 16'h0}, {16'h4800, 16'h4100, 4'h1, 16'h4100},
      {16'h4800, 16'hffff, 4'h1, 16'h7fff}};
   int err_count = 0, checks_done = 0, fetches, n;
   // every output at once, for the reset checks
   wire [23:0] rst_view = {o_we, o_lp, o_rd_wr_n, o_done, o_io, o_low_ram, o_high_ram,
      o_prog_rom, o_addr};
   // =====================
   // design, memory model, clock
   eds_top dut (.*, .o_prog_write_enable(o_we), .o_low_page_prog_write(o_lp));
   eds_mem_model mem (.i_clk(i_clk), .i_prog_rom(o_prog_rom), .i_rd_wr_n(o_rd_wr_n),
      .o_fetch_cnt(fetches));
   initial forever #20 i_clk = ~i_clk;
   // =====================
   // tasks
   task chk(input logic [23:0] got, input logic [23:0] exp);
      checks_done++;
      if (got !== exp) begin
         err_count++;
         $display("BAD %0t got %h want %h", $time, got, exp);
      end
   endtask : chk
   task cfg(input logic [15:0] d);
      i_cfg_wr = 1;
      i_cfg_data = d;
      @(posedge i_clk) #1 i_cfg_wr = 0;
   endtask : cfg
   // one request held until done, strobe cycles collected as {strobes, rd_wr_n, addr}
   task run(input logic x, y, c, input logic [15:0] ya);
      q.delete();
      {i_req, i_x_ext, i_y_ext, i_from_cache, i_x_addr, i_y_addr} = {3'b1_0_0 | {1'b1, x, y}, c, 16'h0010, ya};
      n = 0;
      do begin
         @(posedge i_clk) #1 n++;
         if (o_io | o_low_ram | o_high_ram | o_prog_rom)
            q.push_back({o_io, o_low_ram, o_high_ram, o_prog_rom, o_rd_wr_n, o_addr});
      end while (o_done !== 1'b1 && n < 9);
      chk(24'(o_done), 24'd1);
      i_req = 0;
      @(posedge i_clk) #1;
      chk(24'(o_done), 24'd0);
   endtask : run
   task give_verdict;
      if (err_count == 0 && checks_done > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask : give_verdict
   // =====================
   // main sequence, then watchdog
   initial begin
      repeat (2) @(posedge i_clk);
      #1 i_rst_n = 1;
      chk(rst_view, {3'b001, 5'h00, 16'h0000});
      foreach (rows[i]) begin
         cfg(rows[i][51:36]);
         run(0, 1, 0, rows[i][35:20]);
         chk(21'(q.size()), 21'd1);
         chk(24'(n), 24'd2);
         chk(q[0], {rows[i][19:16], 1'b0, rows[i][15:0]});
      end
      run(0, 1, 0, 16'h0fff);
      chk(21'(q.size()), 21'd0);
      chk(24'(n), 24'd1);
      run(0, 1, 0, 16'h1000);
      chk(21'(q.size()), 21'd0);
      chk(24'(n), 24'd2);
      cfg(16'h0);
      run(1, 1, 0, 16'h4100);
      chk(24'(n), 24'd3);
      chk(q[0], {4'h1, 1'b1, 16'h0010});
      chk(q[1], {4'h4, 1'b0, 16'h4100});
      run(1, 1, 1, 16'h4100);
      chk(21'(q.size()), 21'd1);
      chk(24'(n), 24'd2);
      chk(21'(fetches), 21'd1);
      // data-side read: direction flag stays high on the data step
      i_y_write = 0;
      run(0, 1, 0, 16'h8000);
      chk(q[0], {4'h2, 1'b1, 16'h8000});
      i_y_write = 1;
      // reset in mid-run clears both control bits and the bus
      cfg(16'h4800);
      i_rst_n = 0;
      @(posedge i_clk) #1 i_rst_n = 1;
      chk(rst_view, {3'b001, 5'h00, 16'h0000});
      run(0, 1, 0, 16'h8000);
      chk(q[0], {4'h2, 1'b0, 16'h8000});
      give_verdict;
   end
   initial begin
      #40000;
      err_count++;
      give_verdict;
   end
endmodule : tb_top
bind eds_top eds_monitor mon (.*);
